// ==== hw/cmpctl_pkg.sv ====
// Purpose: Shared constants and types for the comparator control registers
// Assumes: 32-bit plain register port, byte offsets as word addresses
// Notes: Every offset and field position lives here, with the lock, control and read data reset values

package cmpctl_pkg;

	// ************************************************************
	// Register offsets
	// ************************************************************
	localparam logic [7:0] CLKSEL_OFS = 8'h04;
	localparam logic [7:0] WINDOW_OFS = 8'h08;
	localparam logic [7:0] LOCK_OFS = 8'h0c;
	localparam logic [7:0] CMP1_OFS = 8'h10;

	// ************************************************************
	// Field positions
	// ************************************************************
	localparam int FILT_BIT = 21;
	localparam int PWR_BIT = 20;
	localparam int RAW_BIT = 19;
	localparam int BLK_LSB = 16;
	localparam int HYST_LSB = 14;
	localparam int POL_BIT = 13;
	localparam int ROUTE_LSB = 9;
	localparam int PSEL_LSB = 5;
	localparam int NSEL_LSB = 1;
	localparam int EN_BIT = 0;
	localparam int LOCK_ONE_BIT = 0;
	localparam int LOCK_TWO_BIT = 1;
	localparam int LOCK_THREE_BIT = 2;

	// ************************************************************
	// Reset values and codes
	// ************************************************************
	localparam logic [31:0] REG_RESET = 32'h0000_0000;
	localparam logic [2:0] LOCK_RESET = 3'h0;
	localparam logic [2:0] BLK_NONE = 3'h0;
	localparam logic [2:0] BLK_TIMER_ONE = 3'h1;
	localparam logic [2:0] BLK_TIMER_EIGHT = 3'h2;
	localparam logic [2:0] NSEL_FIRST_FLOAT = 3'h5;
	localparam logic [3:0] ROUTE_ONE_BREAK = 4'h1;
	localparam logic [3:0] ROUTE_EIGHT_BREAK = 4'hd;
	localparam logic [3:0] ROUTE_BOTH_BREAK = 4'he;
	// Codes 0 and 12 connect nothing
	localparam logic [15:0] ROUTE_AVAIL_ALL = 16'heffe;

	// Writable control fields of comparator one
	typedef struct packed {
		logic power_speed_select;
		logic [2:0] blanking_source_select;
		logic [1:0] hysteresis_level;
		logic output_invert;
		logic [3:0] timer_route_select;
		logic [2:0] positive_input_select;
		logic [2:0] negative_input_select;
		logic enable;
	} cmpctl_ctrl_t;

	localparam cmpctl_ctrl_t CTRL_RESET = '0;

endpackage

// ==== hw/cmpctl_regs.sv ====
// Purpose: Control and status registers of the comparator block, comparator one path
// Assumes: Comparator outputs arrive asynchronously; blanking inputs are on clk
// Notes: Outputs are all registered; routing adds one cycle of latency

`timescale 1ns/10ps

// Behaviour
// - Clock select 0 picks fast source, 1 picks slow low-power source.
// - Window bit set ties comparator one and two non-inverting inputs together.
// - Lock bits are set by software and cleared only by reset.
// - A locked control register ignores writes; unlocked it is writable.
// - Bit 21 reads comparator one output after the digital filter.
// - Bit 20 selects normal or ultra low power, writable only unlocked.
// - Bit 19 reads the unfiltered comparator one output.
// - Blanking code 0 none, 1 timer one channel five, 2 timer eight.
// - Two-bit hysteresis field selects none, low, medium or high.
// - Polarity bit inverts the comparator one output to the timers; bits 21 and 19 read it uninverted.
// - Four-bit route field connects output to the selected timer input.
// - Routes to timers absent on a variant connect nothing.
// - Bits 7 to 5 select the non-inverting input source.
// - Window, lock and control registers read zero after reset; status bits 21 and 19 follow the pins.
// - Bits 3 to 1 select inverting input; codes 5 to 7 float.
// - Bit 0 switches comparator one on or off.
module cmpctl_regs #(
	parameter logic [15:0] ROUTE_AVAIL = cmpctl_pkg::ROUTE_AVAIL_ALL
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	input wire logic raw_output_pin,
	input wire logic filtered_output_pin,
	input wire logic timer_one_blank,
	input wire logic timer_eight_blank,
	output logic low_power_clock_select,
	output logic window_pair_enable,
	output logic comparator_one_lock,
	output logic comparator_two_lock,
	output logic comparator_three_lock,
	output cmpctl_pkg::cmpctl_ctrl_t comparator_one_control,
	output logic negative_input_connected,
	output logic [15:0] timer_route_out,
	output logic timer_one_break_input,
	output logic timer_eight_break_input
);

	// ************************************************************
	// Storage
	// ************************************************************
	logic clksel_ff;
	logic window_ff;
	logic [2:0] lock_ff;
	cmpctl_pkg::cmpctl_ctrl_t ctrl_ff;
	logic raw_meta_ff;
	logic raw_sync_ff;
	logic filt_meta_ff;
	logic filt_sync_ff;
	logic [31:0] rdata_ff;
	logic nin_conn_ff;
	logic [15:0] route_ff;
	logic brk_one_ff;
	logic brk_eight_ff;

	// ************************************************************
	// Decode
	// ************************************************************
	wire logic hit_clksel = addr == cmpctl_pkg::CLKSEL_OFS;
	wire logic hit_window = addr == cmpctl_pkg::WINDOW_OFS;
	wire logic hit_lock = addr == cmpctl_pkg::LOCK_OFS;
	wire logic hit_cmp1 = addr == cmpctl_pkg::CMP1_OFS;
	wire logic wr_clksel = wr & hit_clksel;
	wire logic wr_window = wr & hit_window;
	wire logic wr_lock = wr & hit_lock;
	// Locked writes are dropped silently, the bus never sees an error
	wire logic wr_cmp1 = wr & hit_cmp1 & ~lock_ff[cmpctl_pkg::LOCK_ONE_BIT];

	wire cmpctl_pkg::cmpctl_ctrl_t wr_ctrl = '{
		power_speed_select: wdata[cmpctl_pkg::PWR_BIT],
		blanking_source_select: wdata[cmpctl_pkg::BLK_LSB +: 3],
		hysteresis_level: wdata[cmpctl_pkg::HYST_LSB +: 2],
		output_invert: wdata[cmpctl_pkg::POL_BIT],
		timer_route_select: wdata[cmpctl_pkg::ROUTE_LSB +: 4],
		positive_input_select: wdata[cmpctl_pkg::PSEL_LSB +: 3],
		negative_input_select: wdata[cmpctl_pkg::NSEL_LSB +: 3],
		enable: wdata[cmpctl_pkg::EN_BIT]
	};

	wire logic nxt_clksel = wr_clksel ? wdata[0] : clksel_ff;
	wire logic nxt_window = wr_window ? wdata[0] : window_ff;
	// Set-only: a written one sticks, a written zero does nothing
	wire logic [2:0] nxt_lock = wr_lock ? (lock_ff | wdata[2:0]) : lock_ff;
	wire cmpctl_pkg::cmpctl_ctrl_t nxt_ctrl = wr_cmp1 ? wr_ctrl : ctrl_ff;

	// ************************************************************
	// Read path
	// ************************************************************
	// Status bits come from the synchronisers only, never from wdata
	wire logic [31:0] cmp1_word = {10'h000, filt_sync_ff, ctrl_ff.power_speed_select,
		raw_sync_ff, ctrl_ff.blanking_source_select, ctrl_ff.hysteresis_level,
		ctrl_ff.output_invert, ctrl_ff.timer_route_select, 1'b0,
		ctrl_ff.positive_input_select, 1'b0, ctrl_ff.negative_input_select,
		ctrl_ff.enable};
	wire logic [31:0] rd_word = hit_cmp1 ? cmp1_word :
		hit_lock ? {29'h0000_0000, lock_ff} :
		hit_window ? {31'h0000_0000, window_ff} :
		hit_clksel ? {31'h0000_0000, clksel_ff} : 32'h0000_0000;
	wire logic [31:0] nxt_rdata = rd ? rd_word : 32'h0000_0000;

	// ************************************************************
	// Output path
	// ************************************************************
	wire logic cmp_pol = filt_sync_ff ^ ctrl_ff.output_invert;
	wire logic blank_on =
		(ctrl_ff.blanking_source_select == cmpctl_pkg::BLK_TIMER_ONE & timer_one_blank) |
		(ctrl_ff.blanking_source_select == cmpctl_pkg::BLK_TIMER_EIGHT &
		timer_eight_blank);
	wire logic cmp_live = cmp_pol & ~blank_on & ctrl_ff.enable;
	wire logic [15:0] nxt_route;
	wire logic nxt_nin_conn =
		ctrl_ff.negative_input_select < cmpctl_pkg::NSEL_FIRST_FLOAT;
	wire logic nxt_brk_one = nxt_route[cmpctl_pkg::ROUTE_ONE_BREAK] |
		nxt_route[cmpctl_pkg::ROUTE_BOTH_BREAK];
	wire logic nxt_brk_eight = nxt_route[cmpctl_pkg::ROUTE_EIGHT_BREAK] |
		nxt_route[cmpctl_pkg::ROUTE_BOTH_BREAK];

	genvar gi;
	generate
		for (gi = 0; gi < 16; gi++) begin : g_route
			// Unavailable codes fall out through the availability mask
			assign nxt_route[gi] = ROUTE_AVAIL[gi] & cmp_live &
				(ctrl_ff.timer_route_select == 4'(gi));
		end
	endgenerate

	// ************************************************************
	// Registers
	// ************************************************************
	always_ff @(posedge clk) begin
		raw_meta_ff <= raw_output_pin;
		raw_sync_ff <= raw_meta_ff;
		filt_meta_ff <= filtered_output_pin;
		filt_sync_ff <= filt_meta_ff;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			clksel_ff <= 1'b0;
			window_ff <= 1'b0;
			lock_ff <= cmpctl_pkg::LOCK_RESET;
			ctrl_ff <= cmpctl_pkg::CTRL_RESET;
			rdata_ff <= cmpctl_pkg::REG_RESET;
		end else begin
			clksel_ff <= nxt_clksel;
			window_ff <= nxt_window;
			lock_ff <= nxt_lock;
			ctrl_ff <= nxt_ctrl;
			rdata_ff <= nxt_rdata;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			route_ff <= 16'h0000;
			brk_one_ff <= 1'b0;
			brk_eight_ff <= 1'b0;
			nin_conn_ff <= 1'b1;
		end else begin
			route_ff <= nxt_route;
			brk_one_ff <= nxt_brk_one;
			brk_eight_ff <= nxt_brk_eight;
			nin_conn_ff <= nxt_nin_conn;
		end
	end

	assign rdata = rdata_ff;
	assign low_power_clock_select = clksel_ff;
	assign window_pair_enable = window_ff;
	assign comparator_one_lock = lock_ff[cmpctl_pkg::LOCK_ONE_BIT];
	assign comparator_two_lock = lock_ff[cmpctl_pkg::LOCK_TWO_BIT];
	assign comparator_three_lock = lock_ff[cmpctl_pkg::LOCK_THREE_BIT];
	// Hysteresis and input selects go straight to the analogue front end
	assign comparator_one_control = ctrl_ff;
	assign negative_input_connected = nin_conn_ff;
	assign timer_route_out = route_ff;
	assign timer_one_break_input = brk_one_ff;
	assign timer_eight_break_input = brk_eight_ff;

	// ************************************************************
	// Checks
	// ************************************************************
	chk_clock_select: assert property (@(posedge clk) disable iff (rst)
		wr_clksel |=> low_power_clock_select == $past(wdata[0]))
		else $error("clock select did not follow write");

	chk_window_pair: assert property (@(posedge clk) disable iff (rst)
		wr && addr == cmpctl_pkg::WINDOW_OFS |=> window_pair_enable == $past(wdata[0]))
		else $error("window pairing did not follow write");

	// The first cycle after reset would compare against the pre-reset value, so skip it
	chk_lock_sticky: assert property (@(posedge clk) disable iff (rst)
		!$past(rst) |-> ($past(lock_ff) & ~lock_ff) == 3'h0)
		else $error("lock bit cleared without reset");

	chk_locked_hold: assert property (@(posedge clk) disable iff (rst)
		wr && hit_cmp1 && comparator_one_lock |=> $stable(comparator_one_control))
		else $error("locked control register changed");

	chk_power_write: assert property (@(posedge clk) disable iff (rst)
		wr && hit_cmp1 && !comparator_one_lock |=>
		comparator_one_control.power_speed_select == $past(wdata[cmpctl_pkg::PWR_BIT]))
		else $error("power mode not written while unlocked");

	chk_status_read: assert property (@(posedge clk) disable iff (rst)
		rd && hit_cmp1 |=> rdata[cmpctl_pkg::FILT_BIT] == $past(filt_sync_ff) &&
		rdata[cmpctl_pkg::RAW_BIT] == $past(raw_sync_ff))
		else $error("status bits misread");

	chk_blank_gate: assert property (@(posedge clk) disable iff (rst)
		ctrl_ff.blanking_source_select == cmpctl_pkg::BLK_TIMER_ONE && timer_one_blank
		|=> timer_route_out == 16'h0000)
		else $error("blanked output still routed");

	chk_route_select: assert property (@(posedge clk) disable iff (rst)
		$onehot0(timer_route_out) && (timer_route_out & ~ROUTE_AVAIL) == 16'h0000)
		else $error("route output not a single available code");

	chk_off_silent: assert property (@(posedge clk) disable iff (rst)
		!ctrl_ff.enable |=> timer_route_out == 16'h0000)
		else $error("disabled comparator drives a route");

	chk_reset_zero: assert property (@(posedge clk)
		rst |=> lock_ff == 3'h0 && ctrl_ff == '0 && window_ff == 1'b0)
		else $error("registers not zero after reset");

	chk_float_flag: assert property (@(posedge clk) disable iff (rst)
		ctrl_ff.negative_input_select >= cmpctl_pkg::NSEL_FIRST_FLOAT [*2]
		|-> !negative_input_connected)
		else $error("floating inverting input flagged connected");

	chk_minus_connected: assert property (@(posedge clk) disable iff (rst)
		ctrl_ff.negative_input_select < cmpctl_pkg::NSEL_FIRST_FLOAT [*2]
		|-> negative_input_connected)
		else $error("selected inverting input flagged floating");

	// Only the write strobe may move the control fields
	chk_hold_idle: assert property (@(posedge clk) disable iff (rst)
		!wr |=> $stable(comparator_one_control))
		else $error("control register changed without a write");

	chk_lock_set: assert property (@(posedge clk) disable iff (rst)
		wr && hit_lock |=> (lock_ff & $past(wdata[2:0])) == $past(wdata[2:0]))
		else $error("written lock bit did not set");

	chk_lock_read: assert property (@(posedge clk) disable iff (rst)
		rd && hit_lock |=> rdata == {29'h0, $past(comparator_three_lock),
		$past(comparator_two_lock), $past(comparator_one_lock)})
		else $error("lock bits misread");

	chk_control_read: assert property (@(posedge clk) disable iff (rst)
		rd && hit_cmp1 |=>
		rdata[cmpctl_pkg::HYST_LSB +: 2] == $past(ctrl_ff.hysteresis_level) &&
		rdata[cmpctl_pkg::PSEL_LSB +: 3] == $past(ctrl_ff.positive_input_select))
		else $error("control fields misread");

	chk_reserved_zero: assert property (@(posedge clk) disable iff (rst)
		rd && hit_cmp1 |=> rdata[31:22] == 10'h000 && !rdata[8] && !rdata[4])
		else $error("reserved control bits read nonzero");

	// ************************************************************
	// Output path checks
	// ************************************************************
	// Judged against the synchronised pin and the fields, not against the live term,
	// so a broken gate inside that term still shows up here
	chk_blank_eight: assert property (@(posedge clk) disable iff (rst)
		ctrl_ff.blanking_source_select == cmpctl_pkg::BLK_TIMER_EIGHT && timer_eight_blank
		|=> timer_route_out == 16'h0000)
		else $error("timer eight blanking ignored");

	chk_invert_low: assert property (@(posedge clk) disable iff (rst)
		ctrl_ff.blanking_source_select == cmpctl_pkg::BLK_NONE &&
		filt_sync_ff == ctrl_ff.output_invert |=> timer_route_out == 16'h0000)
		else $error("low comparator output still routed");

	chk_invert_high: assert property (@(posedge clk) disable iff (rst)
		ctrl_ff.enable && ctrl_ff.blanking_source_select == cmpctl_pkg::BLK_NONE &&
		filt_sync_ff != ctrl_ff.output_invert && ROUTE_AVAIL[ctrl_ff.timer_route_select]
		|=> timer_route_out == 16'h0001 << $past(ctrl_ff.timer_route_select))
		else $error("high comparator output not routed");

	chk_break_one: assert property (@(posedge clk) disable iff (rst)
		timer_one_break_input == (timer_route_out[cmpctl_pkg::ROUTE_ONE_BREAK] ||
		timer_route_out[cmpctl_pkg::ROUTE_BOTH_BREAK]))
		else $error("timer one break input disagrees with route");

	chk_break_eight: assert property (@(posedge clk) disable iff (rst)
		timer_eight_break_input == (timer_route_out[cmpctl_pkg::ROUTE_EIGHT_BREAK] ||
		timer_route_out[cmpctl_pkg::ROUTE_BOTH_BREAK]))
		else $error("timer eight break input disagrees with route");

endmodule

// ==== testbench/cmpctl_timer_model.sv ====
// Purpose: Timer side model: blanking sources and routed comparator input receiver
// Assumes: Timers share the register block clock
// Notes: Compare outputs are registered, as a real timer channel is

`timescale 1ns/10ps

module cmpctl_timer_model (
	input wire logic clk,
	input wire logic [1:0] blank_cmd,
	input wire logic [15:0] route_in,
	output logic timer_one_blank,
	output logic timer_eight_blank,
	output logic [15:0] route_seen
);
	// ****************************************
	// Channel five outputs and input capture
	// ****************************************
	always_ff @(posedge clk) begin
		timer_one_blank <= blank_cmd[0];
		timer_eight_blank <= blank_cmd[1];
		route_seen <= route_in;
	end
endmodule

// ==== testbench/cmpctl_regs_tb_top.sv ====
// Purpose: Self-checking bench for the comparator control registers
// Assumes: Plain register port, read data one cycle after the read strobe
// Notes: Pin changes need two cycles to reach status bits and four to reach seen routes

`timescale 1ns/10ps

module cmpctl_regs_tb_top;
	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] wdata;
		logic [31:0] exp;
	} cmpctl_row_t;
	logic clk, rst, wr, rd, raw, filt, tb1, tb8, lpcs, win, lk1, lk2, lk3, neg, bk1, bk8;
	logic [7:0] addr;
	logic [31:0] wdata, rdata, got;
	logic [1:0] blank_cmd;
	logic [15:0] route, seen;
	cmpctl_pkg::cmpctl_ctrl_t ctrl;
	int error_cnt = 0;
	int n_compared = 0;
	cmpctl_row_t rows [12] = '{'{8'h04, 32'h1, 32'h1}, '{8'h04, 32'h0, 32'h0},
		'{8'h08, 32'h1, 32'h1}, '{8'h08, 32'h0, 32'h0}, '{8'h10, 32'h17feef, 32'h17feef},
		'{8'h10, 32'h280000, 32'h0}, '{8'h10, 32'h100000, 32'h100000},
		'{8'h10, 32'h14000, 32'h14000}, '{8'h10, 32'h28000, 32'h28000},
		'{8'h10, 32'hc000, 32'hc000}, '{8'h14, 32'h1, 32'h0}, '{8'h00, 32'h1, 32'h0}};
	logic [31:0] bctl [7] = '{32'h201, 32'h2201, 32'h10201, 32'h10201, 32'h20201, 32'h30201,
		32'h200};
	logic [1:0] bsel [7] = '{2'h0, 2'h0, 2'h1, 2'h2, 2'h2, 2'h3, 2'h0};
	logic [15:0] bexp [7] = '{16'h2, 16'h0, 16'h0, 16'h2, 16'h0, 16'h2, 16'h0};

	cmpctl_regs cmpctl_regs_i (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata), .raw_output_pin(raw), .filtered_output_pin(filt),
		.timer_one_blank(tb1), .timer_eight_blank(tb8), .low_power_clock_select(lpcs),
		.window_pair_enable(win), .comparator_one_lock(lk1), .comparator_two_lock(lk2),
		.comparator_three_lock(lk3), .comparator_one_control(ctrl),
		.negative_input_connected(neg), .timer_route_out(route),
		.timer_one_break_input(bk1), .timer_eight_break_input(bk8));
	cmpctl_timer_model cmpctl_timer_model_i (.clk(clk), .blank_cmd(blank_cmd),
		.route_in(route), .timer_one_blank(tb1), .timer_eight_blank(tb8), .route_seen(seen));

	// ****************************************
	// Bus cycles and comparisons
	// ****************************************
	task automatic chk(input string name, input logic [31:0] s, input logic [31:0] e);
		n_compared++;
		if (s !== e) begin
			error_cnt++;
			$display("unexpected %s: expected %h seen %h", name, e, s);
		end
	endtask
	task automatic wreg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rreg(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask
	task automatic settle;
		repeat (4) @(posedge clk);
		#1;
	endtask
	task automatic chk_zero;
		for (int i = 1; i < 5; i++) begin
			rreg(8'(i * 4), got);
			chk("reset value", got, 32'h0);
		end
		chk("minus connected", {31'h0, neg}, 32'h1);
		$display("test reset done");
	endtask
	task automatic test_done;
		$display("compares %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// ****************************************
	// Tests
	// ****************************************
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	initial begin
		repeat (4000) @(posedge clk);
		error_cnt++;
		test_done();
	end
	initial begin
		{rst, wr, rd, raw, filt, addr, wdata, blank_cmd} = {5'h10, 8'h00, 32'h0, 2'h0};
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		chk_zero();
		foreach (rows[i]) begin
			wreg(rows[i].addr, rows[i].wdata);
			rreg(rows[i].addr, got);
			chk("readback", got, rows[i].exp);
			if (rows[i].addr == cmpctl_pkg::CMP1_OFS) begin
				got = rows[i].exp;
				chk("fields", 32'(ctrl), 32'({got[20], got[18:9], got[7:5], got[3:0]}));
			end
		end
		wreg(cmpctl_pkg::CLKSEL_OFS, 32'h1);
		wreg(cmpctl_pkg::WINDOW_OFS, 32'h1);
		settle();
		chk("clock and window", {30'h0, lpcs, win}, 32'h3);
		$display("test table done");
		wreg(cmpctl_pkg::CMP1_OFS, 32'h0);
		raw <= 1'b1;
		settle();
		rreg(cmpctl_pkg::CMP1_OFS, got);
		chk("raw status", got, 32'h80000);
		raw <= 1'b0;
		filt <= 1'b1;
		settle();
		rreg(cmpctl_pkg::CMP1_OFS, got);
		chk("filtered status", got, 32'h200000);
		for (int n = 0; n < 16; n++) begin
			wreg(cmpctl_pkg::CMP1_OFS, (32'(n) << 9) | 32'h1);
			settle();
			chk("route", 32'(seen), (n == 0 || n == 12) ? 32'h0 : 32'h1 << n);
			chk("breaks", {30'h0, bk8, bk1}, {30'h0, n == 13 || n == 14, n == 1 || n == 14});
		end
		foreach (bctl[i]) begin
			wreg(cmpctl_pkg::CMP1_OFS, bctl[i]);
			blank_cmd <= bsel[i];
			settle();
			chk("blank path", 32'(seen), 32'(bexp[i]));
		end
		for (int c = 0; c < 8; c++) begin
			wreg(cmpctl_pkg::CMP1_OFS, 32'(c) << 1);
			settle();
			chk("minus connected", {31'h0, neg}, 32'(c < 5));
		end
		$display("test output path done");
		wreg(cmpctl_pkg::CMP1_OFS, 32'h1);
		wreg(cmpctl_pkg::LOCK_OFS, 32'h1);
		wreg(cmpctl_pkg::CMP1_OFS, 32'h17feee);
		rreg(cmpctl_pkg::CMP1_OFS, got);
		chk("locked control", got, 32'h200001);
		wreg(cmpctl_pkg::LOCK_OFS, 32'h0);
		wreg(cmpctl_pkg::LOCK_OFS, 32'h6);
		rreg(cmpctl_pkg::LOCK_OFS, got);
		chk("lock bits", got, 32'h7);
		chk("lock outputs", {29'h0, lk3, lk2, lk1}, 32'h7);
		$display("test lock done");
		filt <= 1'b0;
		settle();
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		chk_zero();
		test_done();
	end
endmodule
